// [rtl/gpio_event_capture.sv]
`timescale 1ns/1ps
`default_nettype none

module gpio_event_capture
  import gpio_rt_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic [7:0] level_i, // sampled pin levels
  input wire gpio_rt_pkg::pin_cfg_t [7:0] cfg_i, // per-pin trigger setup
  input wire logic [7:0] clear_i, // write-one-to-clear strobes
  output logic [7:0] flags_o // capture flags
);

  // ==========================================================================
  // detection
  logic [7:0] prev_r;
  logic [7:0] prev_nxt;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] hit;

  always_comb
  begin
    prev_nxt = level_i;
    hit = '0;
    for (int i = 0; i < 8; i++)
    begin
      if (cfg_i[i].level_trig)
      begin
        hit[i] = (level_i[i] == cfg_i[i].polarity);
      end
      else
      begin
        hit[i] = (level_i[i] != prev_r[i]) && (level_i[i] == cfg_i[i].polarity);
      end
    end
    // set wins over clear; mask plays no part here
    flags_nxt = (flags_r & ~clear_i) | hit;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prev_r <= PIN_LEVEL_RST;
      flags_r <= CAPTURE_FLAG_RST;
    end
    else
    begin
      prev_r <= prev_nxt;
      flags_r <= flags_nxt;
    end
  end

  assign flags_o = flags_r;

endmodule : gpio_event_capture

`default_nettype wire

// [rtl/gpio_port_runtime_events.sv]
`timescale 1ns/1ps
`default_nettype none

module gpio_port_runtime_events
  import gpio_rt_pkg::*;
(
  input wire logic clk_i, // system clock, 125 MHz
  input wire logic rst_n_i, // sync reset, active low
  input wire gpio_rt_pkg::host_req_t req_i, // host register access
  output logic [7:0] rdata_o, // read data, valid cycle after rd
  input wire gpio_rt_pkg::pin_cfg_t [7:0] pin_cfg_i, // per-pin configuration
  input wire logic [7:0] pin_i, // pin levels seen at the pads
  output logic [7:0] pin_o, // pin drive levels
  output logic [7:0] pin_oe_o, // pin output enables, high drives
  output logic notify_o // system notification level
);

  // ==========================================================================
  // register state
  logic [7:0] out_latch_r;
  logic [7:0] out_latch_nxt;
  logic [7:0] notify_mask_r;
  logic [7:0] notify_mask_nxt;
  logic [7:0] pin_level_r;
  logic [7:0] pin_level_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  pin_drive_t drive_r;
  pin_drive_t drive_nxt;
  logic notify_r;
  logic notify_nxt;
  logic [7:0] flags;
  logic [7:0] clear;

  function automatic logic hit_idx(input host_req_t r, input logic [1:0] idx);
    hit_idx = r.wr && (r.idx == idx);
  endfunction : hit_idx

  // ==========================================================================
  // event capture
  gpio_event_capture u_capture (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .level_i(pin_level_r),
    .cfg_i(pin_cfg_i),
    .clear_i(clear),
    .flags_o(flags)
  );

  // ==========================================================================
  // next state
  always_comb
  begin
    out_latch_nxt = out_latch_r;
    notify_mask_nxt = notify_mask_r;
    clear = '0;
    rdata_nxt = rdata_r;
    pin_level_nxt = pin_i;
    if (hit_idx(req_i, OUT_LATCH_IDX))
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (!pin_cfg_i[i].lock)
        begin
          out_latch_nxt[i] = req_i.wdata[i];
        end
      end
    end
    if (hit_idx(req_i, NOTIFY_MASK_IDX))
    begin
      notify_mask_nxt = req_i.wdata;
    end
    if (hit_idx(req_i, CAPTURE_FLAG_IDX))
    begin
      clear = req_i.wdata;
    end
    if (req_i.rd)
    begin
      unique case (req_i.idx)
        OUT_LATCH_IDX: rdata_nxt = out_latch_r;
        PIN_LEVEL_IDX: rdata_nxt = pin_level_r;
        NOTIFY_MASK_IDX: rdata_nxt = notify_mask_r;
        CAPTURE_FLAG_IDX: rdata_nxt = flags;
      endcase
    end
    for (int i = 0; i < 8; i++)
    begin
      drive_nxt.level[i] = out_latch_nxt[i];
      // open drain releases a high bit instead of driving it
      drive_nxt.oe[i] = pin_cfg_i[i].out_en && !(pin_cfg_i[i].open_drain && out_latch_nxt[i]);
    end
    notify_nxt = |(flags & notify_mask_r);
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      out_latch_r <= OUT_LATCH_RST;
      notify_mask_r <= NOTIFY_MASK_RST;
      pin_level_r <= PIN_LEVEL_RST;
      rdata_r <= RDATA_RST;
      drive_r.level <= OUT_LATCH_RST;
      drive_r.oe <= '0;
      notify_r <= 1'b0;
    end
    else
    begin
      out_latch_r <= out_latch_nxt;
      notify_mask_r <= notify_mask_nxt;
      pin_level_r <= pin_level_nxt;
      rdata_r <= rdata_nxt;
      drive_r <= drive_nxt;
      notify_r <= notify_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign pin_o = drive_r.level;
  assign pin_oe_o = drive_r.oe;
  assign notify_o = notify_r;

endmodule : gpio_port_runtime_events

`default_nettype wire

// [rtl/gpio_rt_pkg.sv]
package gpio_rt_pkg;

  // ==========================================================================
  // port geometry
  localparam int unsigned PIN_COUNT = 8;

  // ==========================================================================
  // runtime register indexes on the host register port
  localparam logic [1:0] OUT_LATCH_IDX = 2'h0;
  localparam logic [1:0] PIN_LEVEL_IDX = 2'h1;
  localparam logic [1:0] NOTIFY_MASK_IDX = 2'h2;
  localparam logic [1:0] CAPTURE_FLAG_IDX = 2'h3;

  // ==========================================================================
  // reset values
  localparam logic [7:0] OUT_LATCH_RST = 8'hff;
  localparam logic [7:0] PIN_LEVEL_RST = 8'h00;
  localparam logic [7:0] NOTIFY_MASK_RST = 8'h00;
  localparam logic [7:0] CAPTURE_FLAG_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ==========================================================================
  // host access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] idx;
    logic [7:0] wdata;
  } host_req_t;

  // per-pin configuration, held outside this block
  typedef struct packed {
    logic out_en;
    logic open_drain;
    logic lock;
    logic level_trig;
    logic polarity;
  } pin_cfg_t;

  // pin drive pair
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } pin_drive_t;

endpackage : gpio_rt_pkg

// [verification/gpio_rt_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module gpio_rt_monitor
  import gpio_rt_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire gpio_rt_pkg::host_req_t req_i, // request
  input wire logic [7:0] rdata_o, // read data
  input wire gpio_rt_pkg::pin_cfg_t [7:0] pin_cfg_i, // setup
  input wire logic [7:0] pin_i, // pads
  input wire logic [7:0] pin_o, // drive
  input wire logic [7:0] pin_oe_o, // enables
  input wire logic notify_o // notify
);
  logic [7:0] oe, od, lk, act;
  logic w0, r3;
  assign w0 = req_i.wr && req_i.idx == OUT_LATCH_IDX;
  assign r3 = req_i.rd && !req_i.wr && req_i.idx == CAPTURE_FLAG_IDX;
  always_comb
  begin
    for (int k = 0; k < 8; k++)
    begin
      oe[k] = pin_cfg_i[k].out_en;
      od[k] = pin_cfg_i[k].open_drain;
      lk[k] = pin_cfg_i[k].lock;
      act[k] = pin_cfg_i[k].level_trig && pin_i[k] == pin_cfg_i[k].polarity;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_rd_latch: assert property (req_i.rd && !req_i.wr && req_i.idx == OUT_LATCH_IDX |=> rdata_o == pin_o)
    else $error("latch read");
  chk_lat_write: assert property (w0 |=> pin_o == (($past(req_i.wdata) & ~$past(lk)) | ($past(pin_o) & $past(lk))))
    else $error("latch write");
  chk_lat_hold: assert property (!w0 |=> $stable(pin_o))
    else $error("latch moved");
  chk_oe_map: assert property (!w0 |=> pin_oe_o == ($past(oe) & ~($past(od) & pin_o)))
    else $error("enable map");
  chk_lvl_read: assert property (req_i.rd && req_i.idx == PIN_LEVEL_IDX && $stable(pin_i) && $past(rst_n_i)
    |=> rdata_o == $past(pin_i))
    else $error("level read");
  chk_flag_set: assert property (r3 && $past(rst_n_i) && $past(rst_n_i, 2) && $past(pin_cfg_i) == pin_cfg_i
    && $past(pin_cfg_i, 2) == pin_cfg_i |=> (rdata_o & $past(act, 3)) == $past(act, 3))
    else $error("flag not set");
  chk_flag_keep: assert property (r3 ##1 !req_i.wr ##1 r3 |=> (rdata_o & $past(rdata_o)) == $past(rdata_o))
    else $error("flag lost");
  chk_notify_off: assert property (req_i.wr && req_i.idx == NOTIFY_MASK_IDX && req_i.wdata == 8'h00
    |-> ##2 !notify_o)
    else $error("notify");
  cover property (w0);
  cover property (r3);
  cover property (notify_o);
endmodule : gpio_rt_monitor
bind gpio_port_runtime_events gpio_rt_monitor u_gpio_rt_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
  .rdata_o(rdata_o), .pin_cfg_i(pin_cfg_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .notify_o(notify_o));
`default_nettype wire

// [verification/pin_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_far_end (
  input wire logic [7:0] pin_o, // device drive
  input wire logic [7:0] pin_oe_o, // device enables
  input wire logic [7:0] ext_val_i, // outside level
  output logic [7:0] pin_i // pad levels
);
  // released pins read the outside level given on ext_val_i
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_val_i);
endmodule : pin_far_end
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gpio_rt_pkg::*;
  logic clk_i = 0;
  logic rst_n_i = 0;
  host_req_t req = '0;
  pin_cfg_t [7:0] cfg;
  logic [7:0] rdata, pin_i, pin_o, pin_oe, oe = 0, od = 0, lk = 0, lt = 0, pol = 0, xv = 0, d, e;
  logic notify;
  int miscompares = 0, cmp_count = 0, seed = 69266, latch = 'hff;
  always #4 clk_i = ~clk_i;
  always_comb
    for (int k = 0; k < 8; k++)
      cfg[k] = '{oe[k], od[k], lk[k], lt[k], pol[k]};
  gpio_port_runtime_events u_gpio_port_runtime_events (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .rdata_o(rdata), .pin_cfg_i(cfg), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .notify_o(notify));
  pin_far_end u_pin_far_end (.pin_o(pin_o), .pin_oe_o(pin_oe), .ext_val_i(xv), .pin_i(pin_i));
  task chk(input logic [7:0] s, input logic [7:0] x);
    cmp_count++;
    if (s !== x)
      $display("BAD %0t got %h exp %h", $time, s, x);
    if (s !== x)
      miscompares++;
  endtask : chk
  task acc(input logic w, input logic [1:0] i, input logic [7:0] v);
    @(posedge clk_i);
    req <= '{w, ~w, i, v};
    @(posedge clk_i);
    req <= '0;
    #1;
  endtask : acc
  task end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    acc(0, 0, 0);
    chk(rdata, 8'hff);
    acc(0, 3, 0);
    chk(rdata, 8'h00);
    repeat (8)
    begin
      lk <= 8'($random(seed));
      oe <= 8'($random(seed));
      od <= 8'($random(seed));
      xv <= 8'($random(seed));
      d = 8'($random(seed));
      acc(1, 0, d);
      latch = (d & ~lk) | (latch & lk);
      e = oe & ~(od & 8'(latch));
      chk(pin_o, 8'(latch));
      chk(pin_oe, e);
      acc(1, 1, d);
      acc(0, 1, 0);
      chk(rdata, (e & 8'(latch)) | (~e & xv));
    end
    oe <= 8'h00;
    xv <= 8'hff;
    repeat (3) @(posedge clk_i);
    acc(1, 3, 8'hff);
    acc(0, 3, 0);
    chk(rdata, 8'h00);
    xv <= 8'h00;
    repeat (2) @(posedge clk_i);
    acc(0, 3, 0);
    acc(0, 3, 0);
    chk(rdata, 8'hff);
    chk({7'h0, notify}, 8'h00);
    acc(1, 2, 8'hff);
    @(posedge clk_i);
    #1;
    chk({7'h0, notify}, 8'h01);
    acc(0, 2, 0);
    chk(rdata, 8'hff);
    acc(1, 3, 8'h00);
    acc(0, 3, 0);
    chk(rdata, 8'hff);
    acc(1, 3, 8'h0f);
    acc(0, 3, 0);
    chk(rdata, 8'hf0);
    acc(1, 2, 8'h00);
    lt <= 8'hff;
    acc(1, 3, 8'hff);
    acc(0, 3, 0);
    chk(rdata, 8'hff);
    pol <= 8'hff;
    repeat (2) @(posedge clk_i);
    acc(1, 3, 8'hff);
    acc(0, 3, 0);
    chk(rdata, 8'h00);
    lt <= 8'h00;
    xv <= 8'hff;
    repeat (2) @(posedge clk_i);
    acc(0, 3, 0);
    chk(rdata, 8'hff);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
